// file: tsoc_pkg.sv
package tsoc_pkg;
  localparam logic [1:0] WL_16       = 2'h0;
  localparam logic [1:0] WL_24       = 2'h1;
  localparam logic [1:0] WL_32       = 2'h2;
  localparam int         BITS_16     = 16;
  localparam int         BITS_24     = 24;
  localparam int         BITS_32     = 32;
  localparam int         SAMPLE_W    = 16;
  localparam logic [5:0] LEN_16      = 6'h10;
  localparam logic [5:0] LEN_24      = 6'h18;
  localparam logic [5:0] LEN_32      = 6'h20;
  localparam logic [1:0] WORDS_FRAME = 2'h1;
  localparam logic [2:0] DV_SHORT    = 3'h2;
  localparam logic [2:0] DV_LONG     = 3'h4;
  localparam logic [3:0] DIV_ZERO    = 4'h0;
  localparam logic [4:0] DIV_MIN     = 5'h1;
  localparam int         DIV_W       = 4;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01
  } tsoc_state_t;
endpackage

// file: tsoc_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsoc_clk_if;
  logic       rise;
  logic       fall;
  logic [3:0] divisor;
  logic       master;
  modport gen (input divisor, input master, output rise, output fall);
  modport use_ (output divisor, output master, input rise, input fall);
endinterface
`default_nettype wire

// file: tsoc_clkgen.sv
`timescale 1ns/1ps
`default_nettype none
module tsoc_clkgen
  import tsoc_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic sclk_in_i,
  output var  logic sclk_o,
  tsoc_clk_if.gen   cif
);
  logic [4:0] cnt_reg;
  logic       lvl_reg;
  logic       in_d_reg;
  wire  [4:0] half_w;
  wire        wrap_w;

  // Half period = max(1, divisor) gives fclk/2 or fclk/(2*div)
  assign half_w = (cif.divisor == DIV_ZERO) ? DIV_MIN
                                            : {1'b0, cif.divisor};  // RULE13
  assign wrap_w = (cnt_reg + 5'h1) >= half_w;
  assign cif.rise = cif.master ? (wrap_w & ~lvl_reg)
                               : (sclk_in_i & ~in_d_reg);
  assign cif.fall = cif.master ? (wrap_w & lvl_reg)
                               : (~sclk_in_i & in_d_reg);

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg  <= 5'h0;
      lvl_reg  <= 1'b0;
      in_d_reg <= 1'b0;
    end
    else
    begin
      in_d_reg <= sclk_in_i;
      cnt_reg  <= wrap_w ? 5'h0 : cnt_reg + 5'h1;
      lvl_reg  <= wrap_w ? ~lvl_reg : lvl_reg;  // RULE13
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sclk_o <= 1'b0;
    else
      sclk_o <= cif.master & (wrap_w ? ~lvl_reg : lvl_reg);
  end
endmodule
`default_nettype wire

// file: tsoc_serial_out.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: Master with fresh samples loaded asserts frame start to the DSP.
// RULE2: After frame start the master drives the shared line, shifting words.
// RULE3: Master raises frame end together with its final shifted bit.
// RULE4: Chained slave seeing frame end takes the line next serial cycle.
// RULE5: Every chained device raises frame end when its own shift completes.
// RULE6: With no following device the frame ends after the last shift.
// RULE7: Data valid pulses two or four processing clocks on new data.
// RULE8: DSP catches the data valid pulse with edge-sensitive logic.
// RULE9: In slave mode the DSP makes serial clock and frame start.
// RULE10: DSP starts no slave transfer before the data valid indication.
// RULE11: Slave samples frame start on falling edge, shifts next edge, no gap.
// RULE12: Word length 16, 24 or 32 bits; MSB first, padded at the end.
// RULE13: Master serial clock is processing clock over two or twice divisor.
// RULE14: Outside its own slot the device leaves the shared line undriven.
module tsoc_serial_out
  import tsoc_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire logic                bus_master_select_i,
  input  wire logic [1:0]          word_length_select_i,
  input  wire logic [DIV_W-1:0]    serial_clock_divisor_i,
  input  wire logic                dv_long_mode_i,
  input  wire logic                sample_load_i,
  input  wire logic [SAMPLE_W-1:0] sample_i_i,
  input  wire logic [SAMPLE_W-1:0] sample_q_i,
  input  wire logic                sclk_in_i,
  input  wire logic                frame_start_strobe_i,
  output var  logic                sclk_o,
  output var  logic                frame_start_strobe_o,
  output var  logic                frame_end_strobe_o,
  output var  logic                serial_out_line_o,
  output var  logic                serial_out_line_oe_o,
  output var  logic                output_data_valid_o
);
  tsoc_clk_if cif ();

  tsoc_state_t     state_reg;
  logic [31:0]     shreg_reg;
  logic [31:0]     word_q_reg;
  logic [5:0]      bit_reg;
  logic [1:0]      word_reg;
  logic [5:0]      len_reg;
  logic            pend_reg;
  logic [SAMPLE_W-1:0] hold_i_reg;
  logic [SAMPLE_W-1:0] hold_q_reg;
  logic            fs_seen_reg;
  logic [2:0]      dv_cnt_reg;

  wire  [5:0]      len_w;
  wire  [31:0]     word_i_w;
  wire  [31:0]     word_q_w;
  wire             last_bit_w;
  wire             last_word_w;
  wire             start_w;
  wire             fs_sample_w;
  wire             idle_w;

  assign cif.divisor = serial_clock_divisor_i;
  assign cif.master  = bus_master_select_i;

  tsoc_clkgen u_clkgen
  (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .sclk_in_i (sclk_in_i),
    .sclk_o    (sclk_o),
    .cif       (cif.gen)
  );

  // Disallowed code 11 falls back to 16 bits
  assign len_w = (word_length_select_i == WL_24) ? LEN_24 :
                 (word_length_select_i == WL_32) ? LEN_32 : LEN_16;  // RULE12
  // Left justified, zero padding at the end
  assign word_i_w    = {hold_i_reg, 16'h0000};  // RULE12
  assign word_q_w    = {hold_q_reg, 16'h0000};
  assign last_bit_w  = (bit_reg == len_reg - 6'h1);
  assign last_word_w = (word_reg == WORDS_FRAME);
  // Falling edge sample of external frame start (RULE11)
  assign fs_sample_w = cif.fall & frame_start_strobe_i;  // RULE11
  // A load during a frame waits; a restart mid-slot would garble the line
  assign idle_w  = (state_reg == ST_IDLE);
  // Master starts on own data; slave starts after sampled frame start
  assign start_w = idle_w & (bus_master_select_i
                             ? (pend_reg & cif.rise)      // RULE1
                             : (fs_seen_reg & cif.rise)); // RULE4

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_i_reg <= 16'h0000;
      hold_q_reg <= 16'h0000;
      pend_reg   <= 1'b0;
      dv_cnt_reg <= 3'h0;
    end
    else
    begin
      if (sample_load_i)
      begin
        hold_i_reg <= sample_i_i;
        hold_q_reg <= sample_q_i;
      end
      // New sample wins over the start that consumes the old one
      pend_reg   <= sample_load_i | (pend_reg & ~start_w);
      if (sample_load_i)
        dv_cnt_reg <= dv_long_mode_i ? DV_LONG : DV_SHORT;  // RULE7
      else if (dv_cnt_reg != 3'h0)
        dv_cnt_reg <= dv_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      output_data_valid_o <= 1'b0;
    else
      output_data_valid_o <= sample_load_i | (dv_cnt_reg > 3'h1);  // RULE7
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fs_seen_reg <= 1'b0;
    else if (fs_sample_w && !bus_master_select_i)
      fs_seen_reg <= 1'b1;  // RULE11
    else if (start_w)
      fs_seen_reg <= 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg  <= ST_IDLE;
      shreg_reg  <= 32'h0;
      word_q_reg <= 32'h0;
      bit_reg    <= 6'h0;
      word_reg   <= 2'h0;
      len_reg    <= LEN_16;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (start_w)
          begin
            state_reg  <= ST_SHIFT;  // RULE2
            shreg_reg  <= word_i_w;
            word_q_reg <= word_q_w;
            bit_reg    <= 6'h0;
            word_reg   <= 2'h0;
            len_reg    <= len_w;
          end
        end
        ST_SHIFT:
        begin
          if (cif.rise)
          begin
            if (last_bit_w && last_word_w)
              state_reg <= ST_IDLE;  // RULE6
            else if (last_bit_w)
            begin
              shreg_reg <= word_q_reg;
              bit_reg   <= 6'h0;
              word_reg  <= word_reg + 2'h1;
            end
            else
            begin
              shreg_reg <= {shreg_reg[30:0], 1'b0};  // RULE12
              bit_reg   <= bit_reg + 6'h1;
            end
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Line state follows the shifter on every rising serial edge
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      serial_out_line_o    <= 1'b0;
      serial_out_line_oe_o <= 1'b0;
      frame_end_strobe_o   <= 1'b0;
      frame_start_strobe_o <= 1'b0;
    end
    else if (cif.rise)
    begin
      frame_start_strobe_o <= bus_master_select_i & start_w;  // RULE1
      if (start_w)
      begin
        serial_out_line_oe_o <= 1'b1;  // RULE2
        serial_out_line_o    <= word_i_w[31];
        frame_end_strobe_o   <= 1'b0;
      end
      else if (state_reg == ST_SHIFT && !(last_bit_w && last_word_w))
      begin
        serial_out_line_oe_o <= 1'b1;
        serial_out_line_o    <= last_bit_w ? word_q_reg[31] : shreg_reg[30];
        // High during the final bit of the slot
        frame_end_strobe_o   <= (bit_reg == len_reg - 6'h2)
                                & last_word_w;  // RULE3 RULE5
      end
      else
      begin
        serial_out_line_oe_o <= 1'b0;  // RULE14
        serial_out_line_o    <= 1'b0;
        frame_end_strobe_o   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tsoc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tsoc_chk
  import tsoc_pkg::*;
(
  input wire logic             mclk_i,
  input wire logic             rst_n_i,
  input wire logic             bus_master_select_i,
  input wire logic [DIV_W-1:0] serial_clock_divisor_i,
  input wire logic             dv_long_mode_i,
  input wire logic             sample_load_i,
  input wire logic             sclk_o,
  input wire logic             frame_start_strobe_o,
  input wire logic             frame_end_strobe_o,
  input wire logic             serial_out_line_oe_o,
  input wire logic             output_data_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_dv_go; sample_load_i |=> output_data_valid_o; endproperty
  a_dv_go: assert property (p_dv_go) else $error("dv start");
  property p_dv_two; $rose(output_data_valid_o) && !dv_long_mode_i
    |-> output_data_valid_o [*2] ##1 !output_data_valid_o; endproperty
  a_dv_two: assert property (p_dv_two) else $error("dv short");
  property p_dv_four; $rose(output_data_valid_o) && dv_long_mode_i
    |-> output_data_valid_o [*4] ##1 !output_data_valid_o; endproperty
  a_dv_four: assert property (p_dv_four) else $error("dv long");
  property p_fs_drive; $rose(frame_start_strobe_o)
    |-> serial_out_line_oe_o && bus_master_select_i; endproperty
  a_fs_drive: assert property (p_fs_drive) else $error("fs");
  property p_oe_fs; $rose(serial_out_line_oe_o) && bus_master_select_i
    |-> frame_start_strobe_o; endproperty
  a_oe_fs: assert property (p_oe_fs) else $error("no fs");
  property p_release; $fell(frame_end_strobe_o) |-> !serial_out_line_oe_o;
  endproperty
  a_release: assert property (p_release) else $error("oe");
  property p_div0; $rose(sclk_o) && serial_out_line_oe_o
    && serial_clock_divisor_i == 4'h0 |=> !sclk_o ##1 sclk_o; endproperty
  a_div0: assert property (p_div0) else $error("div0");
  property p_div3; $rose(sclk_o) && serial_out_line_oe_o
    && serial_clock_divisor_i == 4'h3
    |-> sclk_o [*3] ##1 !sclk_o [*3] ##1 sclk_o; endproperty
  a_div3: assert property (p_div3) else $error("div3");
  property p_fe_len; $rose(frame_end_strobe_o) && bus_master_select_i
    && serial_clock_divisor_i == 4'h0
    |-> frame_end_strobe_o [*2] ##1 !frame_end_strobe_o; endproperty
  a_fe_len: assert property (p_fe_len) else $error("fe");
endmodule
bind tsoc_serial_out tsoc_chk u_chk
(
  .mclk_i                 (mclk_i),
  .rst_n_i                (rst_n_i),
  .bus_master_select_i    (bus_master_select_i),
  .serial_clock_divisor_i (serial_clock_divisor_i),
  .dv_long_mode_i         (dv_long_mode_i),
  .sample_load_i          (sample_load_i),
  .sclk_o                 (sclk_o),
  .frame_start_strobe_o   (frame_start_strobe_o),
  .frame_end_strobe_o     (frame_end_strobe_o),
  .serial_out_line_oe_o   (serial_out_line_oe_o),
  .output_data_valid_o    (output_data_valid_o)
);
`default_nettype wire

// file: tsoc_dsp_model.sv
`timescale 1ns/1ps
`default_nettype none
module tsoc_dsp_model
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        m_i,
  input  wire logic        sck_i,
  input  wire logic        dv_i,
  input  wire logic        oe_i,
  input  wire logic        sd_i,
  input  wire logic        fe_i,
  output var  logic        sck_o,
  output var  logic        fs_o,
  output var  logic [63:0] rx_o,
  output var  logic [7:0]  nb_o,
  output var  logic [7:0]  fe_nb_o
);
  logic       dv_q;
  logic       sck_q;
  logic [9:0] cnt;
  wire        sck = m_i ? sck_i : sck_o;
  // Released line shows inverse of last bit
  wire        sd_w = oe_i ? sd_i : ~rx_o[0];
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      {dv_q, sck_q, cnt, sck_o, fs_o, rx_o, nb_o, fe_nb_o} <= '0;
    end
    else
    begin
      dv_q  <= dv_i;
      sck_q <= sck;
      if (dv_i && !dv_q && !m_i)
        cnt <= 10'd560;
      else if (cnt != 10'd0)
        cnt <= cnt - 10'd1;
      // In slave mode clock runs 70 periods after data valid, then stands still; fs spans one fall
      sck_o <= cnt[2];
      fs_o  <= cnt > 10'd552;
      if (sck_q && !sck && oe_i)
      begin
        rx_o <= {rx_o[62:0], sd_w};
        nb_o <= nb_o + 8'd1;
        // First frame end seen marks which bit closed the slot
        if (fe_i && fe_nb_o == 8'd0)
          fe_nb_o <= nb_o + 8'd1;
      end
    end
endmodule
`default_nettype wire

// file: tdm_serial_output_chain_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tdm_serial_output_chain_tb
  import tsoc_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        bus_master_select_i = 1'b0;
  logic        dv_long_mode_i = 1'b0;
  logic        sample_load_i = 1'b0;
  logic [1:0]  word_length_select_i = 2'h0;
  logic [3:0]  serial_clock_divisor_i = 4'h0;
  logic [15:0] sample_i_i = 16'h0;
  logic [15:0] sample_q_i = 16'h0;
  logic        sclk_in_i, frame_start_strobe_i, sclk_o, frame_start_strobe_o;
  logic        frame_end_strobe_o, serial_out_line_o, serial_out_line_oe_o;
  logic        output_data_valid_o;
  logic [63:0] rx;
  logic [7:0]  nb;
  logic [7:0]  fe_nb;
  int          n_mismatch = 0;
  int          total_checks = 0;
  tsoc_serial_out u_dut (.mclk_i, .rst_n_i, .bus_master_select_i,
    .word_length_select_i, .serial_clock_divisor_i, .dv_long_mode_i,
    .sample_load_i, .sample_i_i, .sample_q_i, .sclk_in_i,
    .frame_start_strobe_i, .sclk_o, .frame_start_strobe_o,
    .frame_end_strobe_o, .serial_out_line_o, .serial_out_line_oe_o,
    .output_data_valid_o);
  tsoc_dsp_model u_dsp (.mclk_i, .rst_n_i, .m_i(bus_master_select_i),
    .sck_i(sclk_o), .dv_i(output_data_valid_o), .oe_i(serial_out_line_oe_o),
    .sd_i(serial_out_line_o), .sck_o(sclk_in_i), .fs_o(frame_start_strobe_i),
    .rx_o(rx), .nb_o(nb), .fe_i(frame_end_strobe_o), .fe_nb_o(fe_nb));
  initial
  begin
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic frame(input logic m, input logic [1:0] w,
                       input logic [3:0] d, input logic l);
    int n;
    int i;
    logic [63:0] exp_rx;
    n = (w == WL_24) ? BITS_24 : (w == WL_32) ? BITS_32 : BITS_16;
    @(posedge mclk_i) #1;
    rst_n_i = 1'b0;
    bus_master_select_i = m;
    word_length_select_i = w;
    serial_clock_divisor_i = d;
    dv_long_mode_i = l;
    sample_i_i = 16'hc3a5 ^ {12'h0, d};
    sample_q_i = 16'h5a3c ^ {14'h0, w};
    repeat (8) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    @(posedge mclk_i) #1 sample_load_i = 1'b1;
    @(posedge mclk_i) #1 sample_load_i = 1'b0;
    chk(output_data_valid_o, 64'h1);
    for (i = 0; i < 3000 && nb != 8'(2 * n); i++)
      @(posedge mclk_i);
    if (i == 3000)
    begin
      n_mismatch++;
      end_sim();
    end
    repeat (100) @(posedge mclk_i);
    #1 chk(nb, 64'(2 * n));
    chk(64'(fe_nb), 64'(2 * n));
    exp_rx = (64'(sample_i_i) << (2 * n - 16))
             | (64'(sample_q_i) << (n - 16));
    chk(rx, exp_rx);
    chk(serial_out_line_oe_o, 64'h0);
  endtask
  task automatic t_wordlen;
    for (int c = 0; c < 4; c++)
      frame(1'b1, c[1:0], 4'h0, 1'b0);
  endtask
  task automatic t_divide;
    frame(1'b1, WL_24, 4'h3, 1'b1);
  endtask
  task automatic t_slave;
    frame(1'b0, WL_32, 4'h0, 1'b1);
    frame(1'b0, WL_16, 4'h5, 1'b0);
  endtask
  initial
  begin
    t_wordlen();
    t_divide();
    t_slave();
    end_sim();
  end
endmodule
`default_nettype wire
